// File: design/ddc_top.sv
`timescale 1ns/1ps
`include "ddc_regs.svh"


module ddc_top
    import ddc_pkg::*;
#(
    parameter int CMD_BITS  = `DDC_CMD_BITS,
    parameter int DATA_BITS = `DDC_DATA_BITS
) (
    // clock and reset
    input  wire logic                 i_core_clk,
    input  wire logic                 i_rst,
    // serial link
    input  wire logic                 i_sclk,
    input  wire logic                 i_cs_n,
    input  wire logic                 i_din,
    output logic                      o_dout,
    output logic                      o_dout_oe_n,
    // control
    input  wire logic                 i_apply_hold,
    input  wire logic                 i_overrun_clr,
    // status
    output logic                      o_frame_ready,
    output logic                      o_overrun,
    // channel state
    output logic [DATA_BITS-1:0]      o_channel_a_input,
    output logic [DATA_BITS-1:0]      o_channel_b_input,
    output logic [DATA_BITS-1:0]      o_channel_a_code,
    output logic [DATA_BITS-1:0]      o_channel_b_code,
    output ddc_pkg::ddc_range_type    o_channel_a_range,
    output ddc_pkg::ddc_range_type    o_channel_b_range,
    output logic                      o_channel_a_shdn,
    output logic                      o_channel_b_shdn,
    output logic                      o_ref_internal
);

    localparam int FRAME_BITS = CMD_BITS + DATA_BITS;
    localparam int CHAIN_BITS = FRAME_BITS + `DDC_CHAIN_EXTRA_BITS;
    localparam int CNT_W      = $clog2(FRAME_BITS + 1);

    // ----------------------------------------------------------------
    // parameter checks
    // ----------------------------------------------------------------
    generate
        if (CMD_BITS != `DDC_CMD_BITS || DATA_BITS < 1) begin : g_bad
            $error("ddc_top needs 6 command bits and at least one code bit");
        end
    endgenerate

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    logic [2:0] pin_meta_r;
    logic [2:0] pin_sync_r;
    logic       sclk_prev_r;
    logic       cs_n_prev_r;
    logic       sclk_s;
    logic       cs_n_s;
    logic       din_s;
    logic       sclk_rise;
    logic       sclk_fall;
    logic       cs_rise;

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            // sclk idles low: a high reset value would fake a fall after reset
            pin_meta_r <= 3'h4;
            pin_sync_r <= 3'h4;
        end else begin
            pin_meta_r <= {i_cs_n, i_sclk, i_din};
            pin_sync_r <= pin_meta_r;
        end
    end

    assign cs_n_s = pin_sync_r[2];
    assign sclk_s = pin_sync_r[1];
    assign din_s  = pin_sync_r[0];

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            sclk_prev_r <= 1'b0;
            cs_n_prev_r <= 1'b1;
        end else begin
            sclk_prev_r <= sclk_s;
            cs_n_prev_r <= cs_n_s;
        end
    end

    assign sclk_rise = sclk_s && !sclk_prev_r;
    assign sclk_fall = !sclk_s && sclk_prev_r;
    assign cs_rise   = cs_n_s && !cs_n_prev_r;

    // ----------------------------------------------------------------
    // receive state
    // ----------------------------------------------------------------
    ddc_rx_state_type     rx_state_r;
    logic [CNT_W-1:0]     bit_cnt_r;
    logic [CHAIN_BITS-1:0] chain_r;
    logic                 shift_en;

    // edges while select is high never reach the shifter
    assign shift_en = (rx_state_r == DDC_RX_SHIFT) && !cs_n_s && sclk_rise;

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            rx_state_r <= DDC_RX_IDLE;
        end else begin
            case (rx_state_r)
                DDC_RX_IDLE: begin
                    if (!cs_n_s) begin
                        rx_state_r <= DDC_RX_SHIFT;
                    end
                end
                DDC_RX_SHIFT: begin
                    if (cs_n_s) begin
                        rx_state_r <= DDC_RX_IDLE;
                    end
                end
                default: begin
                    rx_state_r <= DDC_RX_IDLE;
                end
            endcase
        end
    end

    // counter saturates so a long chained stream still leaves the last frame
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            bit_cnt_r <= '0;
        end else if (rx_state_r == DDC_RX_IDLE) begin
            bit_cnt_r <= '0;
        end else if (shift_en && bit_cnt_r != CNT_W'(FRAME_BITS)) begin
            bit_cnt_r <= bit_cnt_r + CNT_W'(1);
        end
    end

    // one stage longer than a frame so the chain lag is a whole frame plus one
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            chain_r <= '0;
        end else if (shift_en) begin
            chain_r <= {chain_r[CHAIN_BITS-2:0], din_s};
        end
    end

    // ----------------------------------------------------------------
    // chain output
    // ----------------------------------------------------------------
    logic dout_r;
    logic dout_oe_n_r;

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            dout_r <= 1'b0;
        end else if (!cs_n_s && sclk_fall) begin
            dout_r <= chain_r[CHAIN_BITS-1];
        end
    end

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            dout_oe_n_r <= 1'b1;
        end else begin
            dout_oe_n_r <= cs_n_s;
        end
    end

    // ----------------------------------------------------------------
    // frame capture into the buffer
    // ----------------------------------------------------------------
    logic                  push_valid_r;
    logic [FRAME_BITS-1:0] push_data_r;
    logic                  buf_in_ready;
    logic                  buf_out_valid;
    logic [FRAME_BITS-1:0] buf_out_data;
    logic                  buf_out_ready;
    logic                  frame_ready_r;
    logic                  overrun_r;

    // short frames are dropped: the command acts only on select rise
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            push_valid_r <= 1'b0;
            push_data_r  <= '0;
        end else begin
            push_valid_r <= cs_rise && (bit_cnt_r == CNT_W'(FRAME_BITS));
            if (cs_rise) begin
                push_data_r <= chain_r[FRAME_BITS-1:0];
            end
        end
    end

    // set wins over a clear in the same cycle
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            overrun_r <= 1'b0;
        end else if (push_valid_r && !buf_in_ready) begin
            overrun_r <= 1'b1;
        end else if (i_overrun_clr) begin
            overrun_r <= 1'b0;
        end
    end

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            frame_ready_r <= 1'b0;
        end else begin
            frame_ready_r <= buf_in_ready;
        end
    end

    assign buf_out_ready = !i_apply_hold;

    ddc_buf2 #(
        .WIDTH (FRAME_BITS),
        .DEPTH (2)
    ) u_buf (
        .i_core_clk  (i_core_clk),
        .i_rst       (i_rst),
        .i_in_valid  (push_valid_r),
        .i_in_data   (push_data_r),
        .o_in_ready  (buf_in_ready),
        .o_out_valid (buf_out_valid),
        .o_out_data  (buf_out_data),
        .i_out_ready (buf_out_ready)
    );

    // ----------------------------------------------------------------
    // command execution
    // ----------------------------------------------------------------
    logic [CMD_BITS-1:0]  cmd;
    logic [DATA_BITS-1:0] code;
    logic                 exec;
    logic [DATA_BITS-1:0] input_a_r;
    logic [DATA_BITS-1:0] input_b_r;
    logic [DATA_BITS-1:0] code_a_r;
    logic [DATA_BITS-1:0] code_b_r;
    ddc_range_type        range_a_r;
    ddc_range_type        range_b_r;
    logic                 shdn_a_r;
    logic                 shdn_b_r;
    logic                 ref_int_r;

    assign cmd  = buf_out_data[FRAME_BITS-1:DATA_BITS];
    assign code = buf_out_data[DATA_BITS-1:0];
    assign exec = buf_out_valid && buf_out_ready;

    // shutdown flags never gate these updates
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            input_a_r <= `DDC_RST_CODE;
            input_b_r <= `DDC_RST_CODE;
            code_a_r  <= `DDC_RST_CODE;
            code_b_r  <= `DDC_RST_CODE;
        end else if (exec) begin
            case (cmd)
                `DDC_CMD_LOAD_BOTH: begin
                    input_a_r <= code;
                    input_b_r <= code;
                    code_a_r  <= code;
                    code_b_r  <= code;
                end
                `DDC_CMD_LOAD_A: begin
                    input_a_r <= code;
                    code_a_r  <= code;
                end
                `DDC_CMD_LOAD_B: begin
                    input_b_r <= code;
                    code_b_r  <= code;
                end
                `DDC_CMD_INPUT_BOTH: begin
                    input_a_r <= code;
                    input_b_r <= code;
                end
                `DDC_CMD_INPUT_A: begin
                    input_a_r <= code;
                end
                `DDC_CMD_INPUT_B: begin
                    input_b_r <= code;
                end
                `DDC_CMD_UPDATE_BOTH: begin
                    code_a_r <= input_a_r;
                    code_b_r <= input_b_r;
                end
                `DDC_CMD_UPDATE_A: begin
                    code_a_r <= input_a_r;
                end
                `DDC_CMD_UPDATE_B: begin
                    code_b_r <= input_b_r;
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            ref_int_r <= `DDC_RST_REF_INTERNAL;
            shdn_a_r  <= `DDC_RST_SHDN;
            shdn_b_r  <= `DDC_RST_SHDN;
        end else if (exec) begin
            case (cmd)
                `DDC_CMD_REF_INTERNAL: ref_int_r <= 1'b1;
                `DDC_CMD_REF_EXTERNAL: ref_int_r <= 1'b0;
                `DDC_CMD_SHDN_BOTH: begin
                    shdn_a_r <= 1'b1;
                    shdn_b_r <= 1'b1;
                end
                `DDC_CMD_SHDN_A:  shdn_a_r <= 1'b1;
                `DDC_CMD_SHDN_B:  shdn_b_r <= 1'b1;
                `DDC_CMD_PWRUP_BOTH: begin
                    shdn_a_r <= 1'b0;
                    shdn_b_r <= 1'b0;
                end
                `DDC_CMD_PWRUP_A: shdn_a_r <= 1'b0;
                `DDC_CMD_PWRUP_B: shdn_b_r <= 1'b0;
                default: begin
                end
            endcase
        end
    end

    // codes above the last range fall through untouched
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            range_a_r <= DDC_RANGE_1_2;
            range_b_r <= DDC_RANGE_1_2;
        end else if (exec && cmd[2:0] <= `DDC_RANGE_LAST) begin
            if (cmd[5:3] == `DDC_CMD_RANGE_A_HI) begin
                range_a_r <= ddc_range_type'(cmd[2:0]);
            end else if (cmd[5:3] == `DDC_CMD_RANGE_B_HI) begin
                range_b_r <= ddc_range_type'(cmd[2:0]);
            end
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign o_dout            = dout_r;
    assign o_dout_oe_n       = dout_oe_n_r;
    assign o_frame_ready     = frame_ready_r;
    assign o_overrun         = overrun_r;
    assign o_channel_a_input = input_a_r;
    assign o_channel_b_input = input_b_r;
    assign o_channel_a_code  = code_a_r;
    assign o_channel_b_code  = code_b_r;
    assign o_channel_a_range = range_a_r;
    assign o_channel_b_range = range_b_r;
    assign o_channel_a_shdn  = shdn_a_r;
    assign o_channel_b_shdn  = shdn_b_r;
    assign o_ref_internal    = ref_int_r;

endmodule : ddc_top

// File: design/ddc_regs.svh
`ifndef DDC_REGS_SVH
`define DDC_REGS_SVH

// ----------------------------------------------------------------
// frame layout
// ----------------------------------------------------------------
`define DDC_CMD_BITS          6
`define DDC_DATA_BITS         10
// chain output lags the serial input by a whole frame plus this many rising edges,
// then waits half a period for the falling edge
`define DDC_CHAIN_EXTRA_BITS  1

// ----------------------------------------------------------------
// command codes
// ----------------------------------------------------------------
`define DDC_CMD_NOP           6'h00
`define DDC_CMD_LOAD_BOTH     6'h01
`define DDC_CMD_LOAD_A        6'h02
`define DDC_CMD_LOAD_B        6'h03
`define DDC_CMD_INPUT_BOTH    6'h04
`define DDC_CMD_INPUT_A       6'h05
`define DDC_CMD_INPUT_B       6'h06
`define DDC_CMD_UPDATE_BOTH   6'h07
`define DDC_CMD_UPDATE_A      6'h09
`define DDC_CMD_UPDATE_B      6'h0a
`define DDC_CMD_REF_INTERNAL  6'h0b
`define DDC_CMD_REF_EXTERNAL  6'h0c
`define DDC_CMD_SHDN_BOTH     6'h0d
`define DDC_CMD_SHDN_A        6'h0e
`define DDC_CMD_SHDN_B        6'h0f
`define DDC_CMD_PWRUP_BOTH    6'h2d
`define DDC_CMD_PWRUP_A       6'h2e
`define DDC_CMD_PWRUP_B       6'h2f
// range commands: upper three bits select the channel, low three the range
`define DDC_CMD_RANGE_A_HI    3'h2
`define DDC_CMD_RANGE_B_HI    3'h6
`define DDC_RANGE_LAST        3'h5

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define DDC_RST_CODE          10'h000
`define DDC_RST_REF_INTERNAL  1'b0
`define DDC_RST_SHDN          1'b0

`endif

// File: design/ddc_pkg.sv
package ddc_pkg;

    // full-scale range, encoded as the low three command bits
    typedef enum logic [2:0] {
        DDC_RANGE_1_2,
        DDC_RANGE_1P5_3,
        DDC_RANGE_2P5_5,
        DDC_RANGE_4P5_9,
        DDC_RANGE_8_16,
        DDC_RANGE_15_30
    } ddc_range_type;

    typedef enum logic [0:0] {
        DDC_RX_IDLE,
        DDC_RX_SHIFT
    } ddc_rx_state_type;

endpackage : ddc_pkg

// File: design/ddc_buf2.sv
`timescale 1ns/1ps

module ddc_buf2 #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 2
) (
    // clock and reset
    input  wire logic             i_core_clk,
    input  wire logic             i_rst,
    // fill side
    input  wire logic             i_in_valid,
    input  wire logic [WIDTH-1:0] i_in_data,
    output logic                  o_in_ready,
    // drain side
    output logic                  o_out_valid,
    output logic [WIDTH-1:0]      o_out_data,
    input  wire logic             i_out_ready
);

    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    generate
        if (DEPTH < 2 || WIDTH < 1) begin : g_bad
            $error("ddc_buf2 needs DEPTH of at least 2 and WIDTH of at least 1");
        end
    endgenerate

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [PW-1:0]    wr_ptr_r;
    logic [PW-1:0]    rd_ptr_r;
    logic [CW-1:0]    count_r;
    logic             push;
    logic             pop;

    assign o_in_ready  = (count_r != CW'(DEPTH));
    assign o_out_valid = (count_r != '0);
    assign o_out_data  = mem_r[rd_ptr_r];
    assign push        = i_in_valid && o_in_ready;
    assign pop         = o_out_valid && i_out_ready;

    function automatic logic [PW-1:0] ddc_wrap(input logic [PW-1:0] p);
        ddc_wrap = (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
    endfunction : ddc_wrap

    // ----------------------------------------------------------------
    // storage
    // ----------------------------------------------------------------
    always_ff @(posedge i_core_clk) begin
        if (push) begin
            mem_r[wr_ptr_r] <= i_in_data;
        end
    end

    // ----------------------------------------------------------------
    // pointers and fill level
    // ----------------------------------------------------------------
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r  <= '0;
        end else begin
            if (push) begin
                wr_ptr_r <= ddc_wrap(wr_ptr_r);
            end
            if (pop) begin
                rd_ptr_r <= ddc_wrap(rd_ptr_r);
            end
            if (push && !pop) begin
                count_r <= count_r + CW'(1);
            end else if (pop && !push) begin
                count_r <= count_r - CW'(1);
            end
        end
    end

endmodule : ddc_buf2

// File: tb/ddc_top_properties.sv
`timescale 1ns/1ps

module ddc_top_properties
    import ddc_pkg::*;
#(
    parameter int CMD_BITS  = 6,
    parameter int DATA_BITS = 10
) (
    // clock and reset
    input logic                   i_core_clk,
    input logic                   i_rst,
    // serial link
    input logic                   i_sclk,
    input logic                   i_cs_n,
    input logic                   i_din,
    input logic                   o_dout,
    input logic                   o_dout_oe_n,
    // control and status
    input logic                   i_apply_hold,
    input logic                   i_overrun_clr,
    input logic                   o_frame_ready,
    input logic                   o_overrun,
    // channel state
    input logic [DATA_BITS-1:0]   o_channel_a_input,
    input logic [DATA_BITS-1:0]   o_channel_b_input,
    input logic [DATA_BITS-1:0]   o_channel_a_code,
    input logic [DATA_BITS-1:0]   o_channel_b_code,
    input ddc_pkg::ddc_range_type o_channel_a_range,
    input ddc_pkg::ddc_range_type o_channel_b_range,
    input logic                   o_channel_a_shdn,
    input logic                   o_channel_b_shdn,
    input logic                   o_ref_internal
);
    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (i_rst);

    logic [4*DATA_BITS+8:0] st;
    assign st = {o_channel_a_input, o_channel_b_input, o_channel_a_code, o_channel_b_code,
                 o_channel_a_range, o_channel_b_range, o_channel_a_shdn, o_channel_b_shdn, o_ref_internal};

    a_oe_floats: assert property (i_cs_n [*5] |-> o_dout_oe_n)
        else $error("chain output driven while deselected");
    a_oe_drives: assert property ((!i_cs_n) [*5] |-> !o_dout_oe_n)
        else $error("chain output not driven while selected");
    a_dout_frozen: assert property (i_cs_n [*5] |=> $stable(o_dout))
        else $error("chain output moved while deselected");
    // eight idle cycles are enough for two queued frames to drain
    a_idle_stable: assert property ((i_cs_n && !i_apply_hold) [*8] |=> $stable(st))
        else $error("state changed with no frame pending");
    a_hold_stable: assert property (i_apply_hold [*3] |=> $stable(st))
        else $error("state changed while executor held");
    a_code_a_tracks: assert property ($changed(o_channel_a_code) |-> o_channel_a_code == o_channel_a_input)
        else $error("channel a converter differs from its input register");
    a_code_b_tracks: assert property ($changed(o_channel_b_code) |-> o_channel_b_code == o_channel_b_input)
        else $error("channel b converter differs from its input register");
    a_range_legal: assert property (o_channel_a_range <= DDC_RANGE_15_30 && o_channel_b_range <= DDC_RANGE_15_30)
        else $error("range outside the six settings");
    a_overrun_clears: assert property ((i_overrun_clr && i_cs_n) [*6] |=> !o_overrun)
        else $error("overrun flag not cleared");
    a_ready_drains: assert property ((!i_apply_hold) [*5] |-> o_frame_ready)
        else $error("buffer not drained");
endmodule : ddc_top_properties

bind ddc_top ddc_top_properties #(
    .CMD_BITS  (CMD_BITS),
    .DATA_BITS (DATA_BITS)
) u_ddc_top_properties (.*);

// File: tb/ddc_spi_master.sv
`timescale 1ns/1ps

module ddc_spi_master (
    // serial link
    output logic o_sclk,
    output logic o_cs_n,
    output logic o_din,
    input  logic i_dout
);
    // ----------------------------------------------------------------
    // frame driver
    // ----------------------------------------------------------------
    // clock idles low and stands still between frames
    initial begin
        o_sclk = 1'h0;
        o_cs_n = 1'h1;
        o_din  = 1'h0;
    end

    task automatic xfer(input logic [31:0] w, input int n, input logic sel, input int lead,
                        input int half, output logic [31:0] got);
        got = '0;
        o_cs_n = !sel;
        #(lead);
        for (int i = n - 1; i >= 0; i--) begin
            o_din = w[i];
            #(half) o_sclk = 1'h1;
            // sample late in the high phase, chain output moves on falls
            #(half - 1) got = {got[30:0], i_dout};
            #1 o_sclk = 1'h0;
        end
        #(half) o_cs_n = 1'h1;
        o_din = !o_din;
        #160;
    endtask : xfer
endmodule : ddc_spi_master

// File: tb/test_dual_dac_command_decoder.sv
`timescale 1ns/1ps

`define CHK(a, b) begin \
    cmp_count++; \
    if ((a) !== (b)) begin \
        mismatches++; \
        $display("Error t=%0t got=%h exp=%h", $time, a, b); \
    end \
end

module test_dual_dac_command_decoder;
    import ddc_pkg::*;

    // ----------------------------------------------------------------
    // signals
    // ----------------------------------------------------------------
    logic          i_core_clk, i_rst, i_sclk, i_cs_n, i_din, i_apply_hold, i_overrun_clr;
    logic          o_dout, o_dout_oe_n, o_frame_ready, o_overrun;
    logic [9:0]    o_channel_a_input, o_channel_b_input, o_channel_a_code, o_channel_b_code;
    ddc_range_type o_channel_a_range, o_channel_b_range;
    logic          o_channel_a_shdn, o_channel_b_shdn, o_ref_internal;
    logic [48:0]   st, st_prev, exp_v;
    logic [48:0]   exp_q[$];
    logic [9:0]    ai, bi, ac, bc;
    logic [2:0]    ar, br;
    logic          sa, sb, rf;
    logic [31:0]   seed, r, got;
    int            mismatches, cmp_count, cycles;
    logic [5:0]    cmds[34] = '{6'h0b, 6'h0c, 6'h0d, 6'h01, 6'h02, 6'h03, 6'h04, 6'h05, 6'h06, 6'h07, 6'h0e,
                                6'h0f, 6'h09, 6'h0a, 6'h2d, 6'h2e, 6'h2f, 6'h10, 6'h11, 6'h12, 6'h13, 6'h14,
                                6'h15, 6'h30, 6'h31, 6'h32, 6'h33, 6'h34, 6'h35, 6'h00, 6'h08, 6'h16, 6'h36, 6'h3f};

    assign st = {o_channel_a_input, o_channel_b_input, o_channel_a_code, o_channel_b_code,
                 o_channel_a_range, o_channel_b_range, o_channel_a_shdn, o_channel_b_shdn, o_ref_internal};

    ddc_top u_ddc_top (.i_core_clk, .i_rst, .i_sclk, .i_cs_n, .i_din, .o_dout, .o_dout_oe_n, .i_apply_hold,
                       .i_overrun_clr, .o_frame_ready, .o_overrun, .o_channel_a_input, .o_channel_b_input,
                       .o_channel_a_code, .o_channel_b_code, .o_channel_a_range, .o_channel_b_range,
                       .o_channel_a_shdn, .o_channel_b_shdn, .o_ref_internal);

    // a released chain output shows the inverse, so a sample taken while floating is caught
    ddc_spi_master u_ddc_spi_master (.o_sclk (i_sclk), .o_cs_n (i_cs_n), .o_din (i_din),
                                     .i_dout (o_dout_oe_n ? !o_dout : o_dout));

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd

    function logic [48:0] pk();
        return {ai, bi, ac, bc, ar, br, sa, sb, rf};
    endfunction : pk

    task automatic model(input logic [5:0] c, input logic [9:0] d);
        logic [48:0] old;
        old = pk();
        case (c)
            6'h01: {ai, bi, ac, bc} = {4{d}};
            6'h02: {ai, ac} = {2{d}};
            6'h03: {bi, bc} = {2{d}};
            6'h04: {ai, bi} = {2{d}};
            6'h05: ai = d;
            6'h06: bi = d;
            6'h07: {ac, bc} = {ai, bi};
            6'h09: ac = ai;
            6'h0a: bc = bi;
            6'h0b: rf = 1'h1;
            6'h0c: rf = 1'h0;
            6'h0d: {sa, sb} = 2'h3;
            6'h0e: sa = 1'h1;
            6'h0f: sb = 1'h1;
            6'h2d: {sa, sb} = 2'h0;
            6'h2e: sa = 1'h0;
            6'h2f: sb = 1'h0;
            default: begin
                if (c[5:3] == 3'h2 && c[2:0] <= 3'h5) ar = c[2:0];
                if (c[5:3] == 3'h6 && c[2:0] <= 3'h5) br = c[2:0];
            end
        endcase
        if (pk() !== old) exp_q.push_back(pk());
    endtask : model

    task automatic frame(input logic [5:0] c, input logic [9:0] d, input int lead);
        model(c, d);
        u_ddc_spi_master.xfer({16'h0, c, d}, 16, 1'h1, lead, 40, got);
    endtask : frame

    task test_done();
        $display("mismatches=%0d comparisons=%0d", mismatches, cmp_count);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : test_done

    // ----------------------------------------------------------------
    // clock, watcher, timeout
    // ----------------------------------------------------------------
    initial begin
        i_core_clk = 1'h0;
        forever #5 i_core_clk = ~i_core_clk;
    end

    // every visible state change consumes the oldest expectation
    always @(negedge i_core_clk) begin
        if (!i_rst && st !== st_prev) begin
            exp_v = (exp_q.size() > 0) ? exp_q.pop_front() : ~st;
            `CHK(st, exp_v)
        end
        st_prev = st;
        cycles++;
        if (cycles == 40000) begin
            mismatches++;
            test_done();
        end
    end

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    initial begin
        seed = 32'h17;
        i_rst = 1'h1;
        i_apply_hold = 1'h0;
        i_overrun_clr = 1'h0;
        {ai, bi, ac, bc, ar, br, sa, sb, rf} = '0;
        repeat (10) @(negedge i_core_clk);
        i_rst = 1'h0;
        repeat (4) @(negedge i_core_clk);
        `CHK(st, 49'h0)
        foreach (cmds[i]) begin
            r = rnd();
            frame(cmds[i], r[9:0], 40);
        end
        repeat (40) begin
            r = rnd();
            frame(cmds[r[15:0] % 34], r[25:16], 40 + r[31:26] * 10);
        end
        // too short a frame, then clocking with select high
        r = rnd();
        u_ddc_spi_master.xfer(r, 15, 1'h1, 40, 40, got);
        u_ddc_spi_master.xfer(r, 16, 1'h0, 40, 40, got);
        `CHK(o_dout_oe_n, 1'h1)
        repeat (4) begin
            r = rnd();
            model(r[15:10], r[9:0]);
            u_ddc_spi_master.xfer(r, 32, 1'h1, 40, 100, got);
            `CHK(got[14:0], r[31:17])
        end
        @(negedge i_core_clk);
        i_apply_hold = 1'h1;
        frame(6'h02, ~ai, 40);
        frame(6'h03, ~bi, 40);
        `CHK(o_frame_ready, 1'h0)
        u_ddc_spi_master.xfer(32'h340, 16, 1'h1, 40, 40, got);
        `CHK(o_overrun, 1'h1)
        @(negedge i_core_clk);
        i_apply_hold = 1'h0;
        repeat (10) @(negedge i_core_clk);
        i_overrun_clr = 1'h1;
        repeat (6) @(negedge i_core_clk);
        i_overrun_clr = 1'h0;
        `CHK(o_overrun, 1'h0)
        `CHK(exp_q.size(), 0)
        test_done();
    end
endmodule : test_dual_dac_command_decoder
